//--- rtl/tirq_params.svh
// constants for the transceiver interrupt request logic
`ifndef TIRQ_PARAMS_SVH
`define TIRQ_PARAMS_SVH

// register byte addresses (low 8 address bits decoded)
`define TIRQ_ADDR_CTRL1 8'h00
`define TIRQ_ADDR_CTRL4 8'h04
`define TIRQ_ADDR_CTRL5 8'h08
`define TIRQ_ADDR_CTRL6 8'h0c
`define TIRQ_ADDR_STATUS 8'h10
`define TIRQ_ADDR_CMD 8'h14
`define TIRQ_ADDR_TXBUF 8'h18
`define TIRQ_ADDR_RXBUF 8'h1c
`define TIRQ_ADDR_TXCNT 8'h20
`define TIRQ_ADDR_MASK 8'h24

// control register 1 fields
`define TIRQ_C1_OPM_LSB 0
`define TIRQ_C1_OPM_MSB 1
`define TIRQ_C1_TMODE 2
`define TIRQ_C1_PMODE 3
`define TIRQ_C1_LVL_LO 4
`define TIRQ_C1_LVL_HI 5
`define TIRQ_CTRL_RST 8'h00

// operating mode codes
`define TIRQ_OPM_TX 2'h1
`define TIRQ_OPM_RX 2'h2

// pending bit positions, also mask bit positions
`define TIRQ_P_STAT 0
`define TIRQ_P_TX 1
`define TIRQ_P_RX 2
`define TIRQ_P_BIT 3
`define TIRQ_PEND_RST 4'h1
`define TIRQ_MASK_RST 4'hf

// status register layout beyond the pending bits
`define TIRQ_S_PWR 4
`define TIRQ_S_AUX 5
`define TIRQ_S_MST_LSB 8
`define TIRQ_MST_W 4

// command register: delete interrupt
`define TIRQ_CMD_DEL 0

// level select codes and byte levels
`define TIRQ_SEL_4 2'h0
`define TIRQ_SEL_8 2'h1
`define TIRQ_SEL_12 2'h2
`define TIRQ_SEL_EMPTY 2'h3
`define TIRQ_LVL_4 5'h04
`define TIRQ_LVL_8 5'h08
`define TIRQ_LVL_12 5'h0c
`define TIRQ_LVL_EMPTY 5'h00
`define TIRQ_CNT_W 5

// axi responses
`define TIRQ_RESP_OKAY 2'h0
`define TIRQ_RESP_SLVERR 2'h2

`endif

//--- rtl/tirq_pkg.sv
// types for the transceiver interrupt request logic
`include "tirq_params.svh"
package tirq_pkg;
    // whole state of the top module
    typedef struct packed {
        logic [7:0] ctrl1; // control register 1
        logic [2:0][7:0] ctrl_x; // control registers 4, 5, 6
        logic [3:0] mask; // interrupt mask
        logic [3:0] pend; // sticky interrupt causes
        logic power_on; // power-up flag
        logic aux_q; // aux flag last cycle
        logic [`TIRQ_MST_W-1:0] mst_q; // mode status last cycle
        logic [`TIRQ_CNT_W-1:0] rxc_q; // rx level last cycle
        logic aw_got; // write address held
        logic [7:0] awaddr; // held write address
        logic w_got; // write data held
        logic [31:0] wdata; // held write data
        logic wen; // low byte lane enabled
        logic bvalid; // write response pending
        logic [1:0] bresp; // write response code
        logic rvalid; // read data pending
        logic [31:0] rdata; // read data
        logic [1:0] rresp; // read response code
        logic rx_reading; // rx buffer read under way
        logic tx_load; // byte load pulse
        logic rx_pop; // byte pop pulse
        logic buf_reset; // buffer reset pulse
        logic [7:0] tx_data; // byte being loaded
    } tirq_state_t;

    // state of the byte counter
    typedef struct packed {
        logic [`TIRQ_CNT_W-1:0] count; // bytes waiting to be sent
        logic hit; // counted down onto level
    } tirq_cnt_state_t;
endpackage

//--- rtl/tirq_cnt_if.sv
// carrier between the top module and the transmit byte counter
`timescale 1ns/100ps
`include "tirq_params.svh"
interface tirq_cnt_if;
    logic load; // one byte loaded
    logic sent; // one byte sent
    logic clr; // reset counter
    logic [1:0] sel; // level select
    logic [`TIRQ_CNT_W-1:0] count; // current count
    logic hit; // level reached while counting down
    modport ctrl (output load, output sent, output clr, output sel, input count, input hit);
    modport cnt (input load, input sent, input clr, input sel, output count, output hit);
endinterface

//--- rtl/tirq_tx_counter.sv
// transmit byte counter with level match
`timescale 1ns/100ps
`include "tirq_params.svh"
module tirq_tx_counter (
    input wire logic clock, // system clock
    input wire logic rst_n, // async reset, active low
    tirq_cnt_if.cnt cif // counter side of the carrier
);
    tirq_pkg::tirq_cnt_state_t st_r; // registered state
    tirq_pkg::tirq_cnt_state_t st_nxt; // next state
    logic [`TIRQ_CNT_W-1:0] target; // selected level

    // level decode, empty code means zero bytes
    always_comb begin
        case (cif.sel)
            `TIRQ_SEL_4: target = `TIRQ_LVL_4;
            `TIRQ_SEL_8: target = `TIRQ_LVL_8;
            `TIRQ_SEL_12: target = `TIRQ_LVL_12;
            default: target = `TIRQ_LVL_EMPTY;
        endcase
    end

    // count up on load, down on send; match only on a net down step
    always_comb begin
        st_nxt = st_r;
        st_nxt.hit = 1'b0;
        if (cif.clr) begin
            st_nxt.count = '0;
        end else if (cif.load && !cif.sent) begin
            st_nxt.count = st_r.count + `TIRQ_CNT_W'(1);
        end else if (cif.sent && !cif.load && st_r.count != '0) begin
            st_nxt.count = st_r.count - `TIRQ_CNT_W'(1);
            st_nxt.hit = (st_nxt.count == target);
        end
    end

    // state register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cif.count = st_r.count;
    assign cif.hit = st_r.hit;
endmodule

//--- rtl/tirq_top.sv
// interrupt request logic of the transceiver, with axi4-lite registers
`timescale 1ns/100ps
`include "tirq_params.svh"
module tirq_top (
    input wire logic clock, // 100 MHz system clock
    input wire logic rst_n, // async reset, active low
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    // transceiver core side
    input wire logic [`TIRQ_MST_W-1:0] mode_status_bits, // mode status from core
    input wire logic aux_supply_flag, // aux supply present
    input wire logic tx_byte_sent, // pulse, byte left the buffer
    input wire logic [`TIRQ_CNT_W-1:0] rx_level, // bytes in rx buffer
    input wire logic rx_error, // pulse, receive error
    input wire logic bit_check_ok, // pulse, bit check passed
    input wire logic [7:0] rx_data, // head byte of rx buffer
    output logic tx_load, // pulse, byte to buffer
    output logic [7:0] tx_data, // byte to buffer
    output logic rx_pop, // pulse, byte taken from rx buffer
    output logic buf_reset, // pulse, data buffer reset
    output logic [1:0] op_mode, // operating mode field
    output logic transparent_sel, // transparent mode select
    output logic irq // interrupt request, active high
);
    tirq_pkg::tirq_state_t st_r; // registered state
    tirq_pkg::tirq_state_t st_nxt; // next state
    tirq_cnt_if cif (); // link to the byte counter

    logic do_wr; // write committed this cycle
    logic rd_take; // read address taken this cycle
    logic wr_c1; // write to control register 1
    logic wr_cx; // write to control register 4, 5 or 6
    logic wr_ctrl; // any control register write
    logic wr_txbuf; // byte loaded into tx buffer
    logic del_cmd; // delete interrupt command
    logic rd_status; // status register read
    logic rd_rxbuf; // rx buffer read
    logic [1:0] sel; // level select field
    logic tx_on; // tx mode, buffered or transparent
    logic rx_on; // rx mode
    logic [`TIRQ_CNT_W-1:0] rx_target; // rx level to match
    logic [3:0] set_v; // events this cycle
    logic [3:0] clr_v; // clearing actions this cycle
    logic [31:0] status_v; // status word as read

    tirq_tx_counter u_cnt (
        .clock(clock),
        .rst_n(rst_n),
        .cif(cif.cnt)
    );

    // bus handshakes: one write and one read in flight at most
    assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
    assign s_axi_wready = !st_r.w_got && !st_r.bvalid;
    assign s_axi_arready = !st_r.rvalid;
    assign do_wr = st_r.aw_got && st_r.w_got && !st_r.bvalid;
    assign rd_take = s_axi_arvalid && s_axi_arready;

    // decoded bus actions; byte lane 0 carries every writable field
    assign wr_c1 = do_wr && st_r.wen && st_r.awaddr == `TIRQ_ADDR_CTRL1;
    assign wr_cx = do_wr && st_r.wen && (st_r.awaddr == `TIRQ_ADDR_CTRL4
        || st_r.awaddr == `TIRQ_ADDR_CTRL5 || st_r.awaddr == `TIRQ_ADDR_CTRL6);
    assign wr_ctrl = wr_c1 || wr_cx;
    assign wr_txbuf = do_wr && st_r.wen && st_r.awaddr == `TIRQ_ADDR_TXBUF;
    assign del_cmd = do_wr && st_r.wen && st_r.awaddr == `TIRQ_ADDR_CMD
        && st_r.wdata[`TIRQ_CMD_DEL];
    assign rd_status = rd_take && s_axi_araddr == `TIRQ_ADDR_STATUS;
    assign rd_rxbuf = rd_take && s_axi_araddr == `TIRQ_ADDR_RXBUF;

    // mode decode from control register 1
    assign sel = {st_r.ctrl1[`TIRQ_C1_LVL_HI], st_r.ctrl1[`TIRQ_C1_LVL_LO]};
    assign tx_on = st_r.ctrl1[`TIRQ_C1_OPM_MSB:`TIRQ_C1_OPM_LSB] == `TIRQ_OPM_TX;
    assign rx_on = st_r.ctrl1[`TIRQ_C1_OPM_MSB:`TIRQ_C1_OPM_LSB] == `TIRQ_OPM_RX;

    // rx level decode, same code table as the counter
    always_comb begin
        case (sel)
            `TIRQ_SEL_4: rx_target = `TIRQ_LVL_4;
            `TIRQ_SEL_8: rx_target = `TIRQ_LVL_8;
            `TIRQ_SEL_12: rx_target = `TIRQ_LVL_12;
            default: rx_target = `TIRQ_LVL_EMPTY;
        endcase
    end

    // counter drive; a control write in tx mode empties the buffer
    assign cif.load = wr_txbuf;
    assign cif.sent = tx_byte_sent;
    assign cif.clr = wr_ctrl && tx_on;
    assign cif.sel = sel;

    // interrupt events
    always_comb begin
        set_v = '0;
        // any edge of a mode status bit, either direction
        set_v[`TIRQ_P_STAT] = (mode_status_bits != st_r.mst_q)
            || (aux_supply_flag && !st_r.aux_q);
        // tx level, only with the buffer in use
        set_v[`TIRQ_P_TX] = cif.hit && tx_on
            && !st_r.ctrl1[`TIRQ_C1_TMODE];
        // rx level or error, held off while the host reads the buffer
        if (rx_on && !st_r.ctrl1[`TIRQ_C1_TMODE] && !rd_rxbuf && !st_r.rx_reading) begin
            if (sel == `TIRQ_SEL_EMPTY) begin
                set_v[`TIRQ_P_RX] = rx_error;
            end else begin
                set_v[`TIRQ_P_RX] = rx_level != st_r.rxc_q && rx_level == rx_target;
            end
        end
        // bit check only when pattern mode is off
        set_v[`TIRQ_P_BIT] = rx_on && bit_check_ok
            && !st_r.ctrl1[`TIRQ_C1_PMODE];
    end

    // clearing actions; a status read touches only the status cause
    always_comb begin
        clr_v = '0;
        clr_v[`TIRQ_P_STAT] = rd_status || del_cmd;
        clr_v[`TIRQ_P_TX] = wr_txbuf || wr_ctrl || del_cmd;
        clr_v[`TIRQ_P_RX] = rd_rxbuf || wr_ctrl || del_cmd;
        clr_v[`TIRQ_P_BIT] = rd_rxbuf || wr_ctrl || del_cmd;
    end

    // status word: causes, flags and live mode status
    always_comb begin
        status_v = '0;
        status_v[3:0] = st_r.pend;
        status_v[`TIRQ_S_PWR] = st_r.power_on;
        status_v[`TIRQ_S_AUX] = aux_supply_flag;
        status_v[`TIRQ_S_MST_LSB +: `TIRQ_MST_W] = mode_status_bits;
    end

    // next state of the whole block
    always_comb begin
        st_nxt = st_r;
        st_nxt.tx_load = 1'b0;
        st_nxt.rx_pop = 1'b0;
        st_nxt.buf_reset = 1'b0;
        st_nxt.mst_q = mode_status_bits;
        st_nxt.aux_q = aux_supply_flag;
        st_nxt.rxc_q = rx_level;
        // set wins over a clear in the same cycle
        st_nxt.pend = (st_r.pend & ~clr_v) | set_v;
        // power-up flag is read-to-clear
        if (rd_status) begin
            st_nxt.power_on = 1'b0;
        end
        // write address and data captured in either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axi_wdata;
            st_nxt.wen = s_axi_wstrb[0];
        end
        // commit a write once both halves are here
        if (do_wr) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = `TIRQ_RESP_OKAY;
            case (st_r.awaddr)
                `TIRQ_ADDR_CTRL1: begin
                    if (st_r.wen) begin
                        st_nxt.ctrl1 = st_r.wdata[7:0];
                    end
                end
                `TIRQ_ADDR_CTRL4: begin
                    if (st_r.wen) begin
                        st_nxt.ctrl_x[0] = st_r.wdata[7:0];
                    end
                end
                `TIRQ_ADDR_CTRL5: begin
                    if (st_r.wen) begin
                        st_nxt.ctrl_x[1] = st_r.wdata[7:0];
                    end
                end
                `TIRQ_ADDR_CTRL6: begin
                    if (st_r.wen) begin
                        st_nxt.ctrl_x[2] = st_r.wdata[7:0];
                    end
                end
                `TIRQ_ADDR_MASK: begin
                    if (st_r.wen) begin
                        st_nxt.mask = st_r.wdata[3:0];
                    end
                end
                `TIRQ_ADDR_TXBUF: begin
                    st_nxt.tx_load = st_r.wen;
                    if (st_r.wen) begin
                        st_nxt.tx_data = st_r.wdata[7:0];
                    end
                end
                `TIRQ_ADDR_CMD: begin
                    // effect handled through del_cmd
                end
                default: begin
                    st_nxt.bresp = `TIRQ_RESP_SLVERR; // unmapped or read-only
                end
            endcase
            // buffer reset only matters while transmitting
            st_nxt.buf_reset = wr_ctrl && tx_on;
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        // read: data registered when the address is taken
        if (rd_take) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = `TIRQ_RESP_OKAY;
            st_nxt.rdata = '0;
            case (s_axi_araddr)
                `TIRQ_ADDR_CTRL1: st_nxt.rdata[7:0] = st_r.ctrl1;
                `TIRQ_ADDR_CTRL4: st_nxt.rdata[7:0] = st_r.ctrl_x[0];
                `TIRQ_ADDR_CTRL5: st_nxt.rdata[7:0] = st_r.ctrl_x[1];
                `TIRQ_ADDR_CTRL6: st_nxt.rdata[7:0] = st_r.ctrl_x[2];
                `TIRQ_ADDR_STATUS: st_nxt.rdata = status_v;
                `TIRQ_ADDR_RXBUF: begin
                    st_nxt.rdata[7:0] = rx_data;
                    st_nxt.rx_pop = 1'b1;
                    st_nxt.rx_reading = 1'b1;
                end
                `TIRQ_ADDR_TXCNT: st_nxt.rdata[`TIRQ_CNT_W-1:0] = cif.count;
                `TIRQ_ADDR_MASK: st_nxt.rdata[3:0] = st_r.mask;
                `TIRQ_ADDR_CMD: st_nxt.rdata = '0;
                `TIRQ_ADDR_TXBUF: st_nxt.rdata = '0;
                default: st_nxt.rresp = `TIRQ_RESP_SLVERR;
            endcase
        end
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
            st_nxt.rx_reading = 1'b0;
        end
    end

    // state register; power-up sets the flag and its cause
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.ctrl1 <= `TIRQ_CTRL_RST;
            st_r.mask <= `TIRQ_MASK_RST;
            st_r.pend <= `TIRQ_PEND_RST;
            st_r.power_on <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign tx_load = st_r.tx_load;
    assign tx_data = st_r.tx_data;
    assign rx_pop = st_r.rx_pop;
    assign buf_reset = st_r.buf_reset;
    assign op_mode = st_r.ctrl1[`TIRQ_C1_OPM_MSB:`TIRQ_C1_OPM_LSB];
    assign transparent_sel = st_r.ctrl1[`TIRQ_C1_TMODE];
    // level output while any unmasked cause is pending
    assign irq = |(st_r.pend & st_r.mask);
endmodule

//--- tb/tirq_props.sv
// concurrent checks on the ports of the interrupt request block
`timescale 1ns/100ps
`include "tirq_params.svh"
module tirq_props (
    input logic clock, // system clock
    input logic rst_n, // reset, active low
    input logic [7:0] s_axi_araddr, // read address
    input logic s_axi_arvalid, // read address valid
    input logic s_axi_arready, // read address ready
    input logic s_axi_rvalid, // read data valid
    input logic s_axi_bvalid, // write response valid
    input logic [`TIRQ_MST_W-1:0] mode_status_bits, // core mode status
    input logic aux_supply_flag, // aux supply flag
    input logic tx_load, // byte push pulse
    input logic rx_pop, // byte pop pulse
    input logic buf_reset, // buffer reset pulse
    input logic [1:0] op_mode, // mode field
    input logic irq // interrupt request
);
    // rx buffer read address taken at this edge
    wire rx_hs = s_axi_arvalid && s_axi_arready && s_axi_araddr == `TIRQ_ADDR_RXBUF;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_event_irq: assert property (
        ($changed(mode_status_bits) || $rose(aux_supply_flag)) |=> irq)
        else $error("status event left irq low");
    a_powerup_irq: assert property ($rose(rst_n) |-> irq)
        else $error("irq low after power-up");
    a_buf_reset_tx: assert property (
        buf_reset |-> s_axi_bvalid && $past(op_mode) == `TIRQ_OPM_TX)
        else $error("buffer reset outside a tx mode write");
    a_tx_load_write: assert property (tx_load |-> $rose(s_axi_bvalid) ##1 !tx_load)
        else $error("byte push not tied to one write");
    a_rx_pop_read: assert property (
        rx_pop |-> $past(rx_hs) || $past(rx_hs, 2))
        else $error("byte pop without buffer read");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    a_mode_on_write: assert property ($changed(op_mode) |-> $rose(s_axi_bvalid))
        else $error("mode changed outside a write");
    // main scenarios reached
    c_buf_reset: cover property (buf_reset);
    c_rx_pop: cover property (rx_pop);
    c_irq_cleared: cover property (irq ##1 !irq);
endmodule
bind tirq_top tirq_props u_props (.clock(clock), .rst_n(rst_n),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
    .mode_status_bits(mode_status_bits), .aux_supply_flag(aux_supply_flag),
    .tx_load(tx_load), .rx_pop(rx_pop), .buf_reset(buf_reset), .op_mode(op_mode), .irq(irq));

//--- tb/tirq_core_model.sv
// behavioural model of the transceiver core around the data buffer
`timescale 1ns/100ps
`include "tirq_params.svh"
module tirq_core_model (
    input logic clock, // system clock
    input logic rst_n, // reset, active low
    input logic send_req, // bench asks one byte out
    input logic push_req, // bench asks one byte in
    input logic tx_load, // byte pushed by the block
    input logic rx_pop, // byte taken by the block
    input logic buf_reset, // buffer reset from the block
    output logic tx_byte_sent, // pulse, byte transmitted
    output logic [`TIRQ_CNT_W-1:0] rx_level, // bytes received
    output logic [7:0] rx_data // head byte, follows the level
);
    logic [`TIRQ_CNT_W-1:0] tx_cnt; // bytes waiting to go out
    wire snd = send_req && tx_cnt != 5'h00; // an empty buffer sends nothing
    assign rx_data = {3'h5, rx_level}; // pattern so a stale byte shows
    // byte counts; a reset empties the whole buffer
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_cnt <= 5'h00;
            rx_level <= 5'h00;
            tx_byte_sent <= 1'b0;
        end else begin
            tx_byte_sent <= snd;
            if (buf_reset) begin
                tx_cnt <= 5'h00;
                rx_level <= 5'h00;
            end else begin
                tx_cnt <= tx_cnt + 5'(tx_load) - 5'(snd);
                rx_level <= rx_level + 5'(push_req) - 5'(rx_pop);
            end
        end
    end
endmodule

//--- tb/testbench.sv
// self-checking bench for the interrupt request block
`timescale 1ns/100ps
`include "tirq_params.svh"
module testbench;
    logic clock = 1'b0; // system clock
    logic rst_n = 1'b0; // reset, active low
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0; // write side
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0; // read side
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00; // addresses
    logic [31:0] s_axi_wdata = 32'h0; // write data
    logic [3:0] s_axi_wstrb = 4'h0; // strobes
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid; // slave
    logic [1:0] s_axi_bresp, s_axi_rresp, op_mode; // responses, mode
    logic [31:0] s_axi_rdata; // read data
    logic [`TIRQ_MST_W-1:0] mode_status_bits = '0; // core mode status
    logic aux_supply_flag = 1'b0, rx_error = 1'b0, bit_check_ok = 1'b0; // core events
    logic send_req = 1'b0, push_req = 1'b0; // requests to the core model
    logic tx_byte_sent, tx_load, rx_pop, buf_reset, transparent_sel, irq; // outputs
    logic [`TIRQ_CNT_W-1:0] rx_level; // bytes received
    logic [7:0] rx_data, tx_data; // buffer bytes
    int n_fail = 0, comparisons = 0, cyc = 0; // counts
    logic [31:0] d; // last read data
    logic [1:0] r; // last response
    // reset reads: ctrl1, ctrl4, mask, count, command, unmapped
    logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h24, 8'h20, 8'h14, 8'h30};
    logic [31:0] re [6] = '{32'h0, 32'h0, 32'hf, 32'h0, 32'h0, 32'h0};
    logic [1:0] rr [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2};
    tirq_top dut (.*);
    tirq_core_model core (.*);
    always #5 clock = ~clock;
    // hang guard, the run needs well under a thousand cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            final_report;
        end
    end
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // irq looked at mid-cycle after one more edge, so a cause set by
    // stimulus driven at the last edge has reached the register
    task automatic ckirq(input logic e);
        @(posedge clock);
        @(negedge clock);
        chk({31'h0, irq}, {31'h0, e});
        @(posedge clock);
    endtask
    // a leading edge keeps a release and the next raise apart
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic ha, hw, hb;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge clock);
            ha = s_axi_awvalid && s_axi_awready;
            hw = s_axi_wvalid && s_axi_wready;
            hb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clock);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
        end while (!hb);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        logic ha, hb;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge clock);
            ha = s_axi_arvalid && s_axi_arready;
            hb = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clock);
            if (ha) s_axi_arvalid <= 1'b0;
        end while (!hb);
        s_axi_rready <= 1'b0;
    endtask
    // one byte leaves the core, then the registered match settles
    task automatic snd;
        send_req <= 1'b1;
        @(posedge clock);
        send_req <= 1'b0;
        repeat (4) @(posedge clock);
    endtask
    // one receive error or bit check pulse
    task automatic ev(input logic bitchk);
        if (bitchk) bit_check_ok <= 1'b1;
        else rx_error <= 1'b1;
        @(posedge clock);
        bit_check_ok <= 1'b0;
        rx_error <= 1'b0;
        repeat (2) @(posedge clock);
    endtask
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        ckirq(1'b1);
        for (int i = 0; i < 6; i++) begin
            rd(ra[i]);
            chk(d, re[i]);
            chk({30'h0, r}, {30'h0, rr[i]});
        end
        wr(8'h10, 32'h0);
        chk({30'h0, r}, 32'h2);
        $display("test reset values done");
        rd(8'h10);
        chk(d, 32'h11);
        ckirq(1'b0);
        mode_status_bits <= 4'h2;
        ckirq(1'b1);
        wr(8'h14, 32'h1);
        ckirq(1'b0);
        mode_status_bits <= 4'h0;
        ckirq(1'b1);
        wr(8'h24, 32'h0);
        ckirq(1'b0);
        wr(8'h24, 32'hf);
        ckirq(1'b1);
        rd(8'h10);
        chk(d, 32'h1);
        aux_supply_flag <= 1'b1;
        ckirq(1'b1);
        rd(8'h10);
        chk(d, 32'h21);
        ckirq(1'b0);
        $display("test status events done");
        wr(8'h00, 32'h01); // tx mode, level of 4 bytes
        for (int i = 0; i < 5; i++) wr(8'h18, 32'h40 + i);
        chk({24'h0, tx_data}, 32'h44);
        rd(8'h20);
        chk(d, 32'h5);
        snd;
        ckirq(1'b1);
        rd(8'h10);
        chk(d, 32'h22);
        ckirq(1'b1);
        wr(8'h18, 32'h0);
        ckirq(1'b0);
        wr(8'h00, 32'h31); // level code empty
        rd(8'h20);
        chk(d, 32'h0);
        wr(8'h18, 32'h55);
        snd;
        ckirq(1'b1);
        wr(8'h0c, 32'h0);
        ckirq(1'b0);
        wr(8'h00, 32'h05); // transparent tx
        chk({29'h0, transparent_sel, op_mode}, 32'h5);
        for (int i = 0; i < 5; i++) wr(8'h18, 32'h0);
        snd;
        ckirq(1'b0);
        $display("test transmit levels done");
        wr(8'h00, 32'h02); // rx mode, level of 4 bytes
        push_req <= 1'b1;
        repeat (4) @(posedge clock);
        push_req <= 1'b0;
        ckirq(1'b1);
        rd(8'h1c);
        chk(d, 32'ha4);
        ckirq(1'b0);
        wr(8'h00, 32'h32); // level code receive error
        ev(1'b0);
        ckirq(1'b1);
        wr(8'h04, 32'h0);
        ckirq(1'b0);
        wr(8'h00, 32'h02);
        ev(1'b1);
        ckirq(1'b1);
        wr(8'h14, 32'h1);
        ckirq(1'b0);
        wr(8'h00, 32'h0a); // pattern select set
        ev(1'b1);
        ckirq(1'b0);
        wr(8'h00, 32'h12); // rx mode, level of 8 bytes, three already held
        push_req <= 1'b1;
        repeat (5) @(posedge clock);
        push_req <= 1'b0;
        ckirq(1'b1);
        $display("test receive causes done");
        final_report;
    end
endmodule
